/* File: logic/limit_monitor_consts.vh */
// Purpose: Constants of the process limit monitor.
// Assumes: AHB-Lite register access, 125 MHz clock.
// Notes: Word indices; each process value owns a block of eight words.
`ifndef LIMIT_MONITOR_CONSTS_VH
`define LIMIT_MONITOR_CONSTS_VH

`define PV_COUNT 9
`define LIMITS_PER_PV 5
`define CLK_FREQ_KHZ 125000
`define UPDATE_PERIOD_MS 10
`define HELP_DELAY_S 3

// Process value numbering.
`define PV_MASSFLOW 4'h0
`define PV_VOLFLOW 4'h1
`define PV_STDVOLFLOW 4'h2
`define PV_DENSITY 4'h3

// Slots inside one process value block (word index).
`define SLOT_UPPER_ALARM 3'h0
`define SLOT_UPPER_WARN 3'h1
`define SLOT_LOWER_WARN 3'h2
`define SLOT_LOWER_ALARM 3'h3
`define SLOT_HYST 3'h4
`define SLOT_RESOLUTION 3'h5
`define SLOT_VALUE 3'h6
`define SLOT_STATUS 3'h7

// Global registers, word index with haddr[9] set.
`define GREG_CTRL 4'h0
`define GREG_SUP_SELECT 4'h1
`define GREG_SUP_SAVE 4'h2
`define GREG_VIEW 4'h3
`define GREG_CH_CFG 4'h4
`define GREG_CH_SCALE 4'h8
`define GREG_SUMMARY 4'hc

// Channel configuration fields.
`define CH_SEL_MSB 3
`define CH_TYPE_LSB 4
`define CH_TYPE_MSB 5
`define CH_FS_EN_BIT 6
`define CH_TYPE_OFF 2'h0
`define CH_TYPE_CURRENT 2'h1
`define CH_TYPE_PULSE 2'h2
`define CH_TYPE_FREQ 2'h3

`define RESOLUTION_RESET 32'h00000002
`define SCALE_DENSITY_DEFAULT 32'h00003e80
`define SCALE_RESET 32'h00000000

`endif

/* File: logic/process_limit_monitor.v */
// Purpose: Limit alarms and warnings for nine process values, fail-safe drive and channel routing.
// Assumes: Front-end strobes values on hclk; key, access and safety pins are asynchronous.
// Notes: Limit registers hold signed 32-bit values in the unit and scaling of their process value.
// Overview of operation
// - Evaluate limits once every 10 ms.
// - Five limit settings per process value.
// - Alarm above upper or below lower alarm.
// - Warning above upper or below lower warning.
// - Upper alarm clears below limit minus hysteresis.
// - Lower alarm clears above limit plus hysteresis.
// - No hysteresis: clears crossing same limit back.
// - Lower warning zero flags negative flow.
// - Individual alarm outputs only in individual mode.
// - Fail-safe needs output type, enable, routed alarm.
// - Warnings never force fail-safe.
// - Safety units: channel 1 mass, volume, density.
// - Otherwise every value allowed on channels.
// - One resolution shared by a value's parameters.
// - Marked alarms unsuppressed; applied only on save.
// - Help text after three idle seconds, with edit access only.
// - Density selection defaults upper scaling 1600.0.
// - Read-only view without edit access.
`timescale 1ns/1ns
`include "limit_monitor_consts.vh"

module process_limit_monitor #(
	parameter UPDATE_CYCLES = `UPDATE_PERIOD_MS * `CLK_FREQ_KHZ,
	parameter HELP_CYCLES = `HELP_DELAY_S * `CLK_FREQ_KHZ * 1000
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire pv_load,
	input wire [3:0] pv_sel,
	input wire [31:0] pv_data,
	input wire key_press_pin,
	input wire edit_access_pin,
	input wire safety_rated_pin,
	output reg [8:0] alarm_out,
	output reg [8:0] warn_out,
	output reg [3:0] failsafe_out,
	output reg update_tick,
	output reg help_show,
	output reg read_only_view
);

	localparam NLIM = `PV_COUNT * `LIMITS_PER_PV;

	// Upper limits trip above, lower limits trip below; hysteresis widens the way back.
	// Both sides are widened to 34 bits so that a limit near full scale plus its hysteresis cannot wrap.
	function eval_limit;
		input state;
		input upper;
		input signed [31:0] v;
		input signed [31:0] lim;
		input [31:0] hyst;
		reg signed [33:0] back;
		reg signed [33:0] v_ext;
		begin
			// A concatenation is unsigned, so it is held in a signed variable before any compare.
			// Otherwise a negative value would compare as a huge one against a positive threshold.
			v_ext = {{2{v[31]}}, v};
			// With zero hysteresis the way back is the limit itself, so the state clears on crossing it.
			back = upper ? ({{2{lim[31]}}, lim} - {2'b00, hyst}) : ({{2{lim[31]}}, lim} + {2'b00, hyst});
			if (!state)
				eval_limit = upper ? (v > lim) : (v < lim);
			else if (upper)
				eval_limit = !(v_ext < back);
			else
				eval_limit = !(v_ext > back);
		end
	endfunction

	// A refused selection leaves the whole channel word unchanged, type and enable included.
	function ch_allowed;
		input [1:0] ch;
		input [3:0] sel;
		input safe;
		begin
			if (sel >= `PV_COUNT)
				ch_allowed = 1'b0;
			else if (ch == 2'd0 && safe)
				ch_allowed = (sel == `PV_MASSFLOW) || (sel == `PV_VOLFLOW) || (sel == `PV_DENSITY);
			else
				ch_allowed = 1'b1;
		end
	endfunction

	function output_active;
		input [31:0] cfg;
		begin
			output_active = (cfg[`CH_TYPE_MSB:`CH_TYPE_LSB] != `CH_TYPE_OFF) && cfg[`CH_FS_EN_BIT];
		end
	endfunction

	reg [31:0] lim_reg [0:NLIM-1];
	reg [31:0] res_reg [0:`PV_COUNT-1];
	reg [31:0] shadow_reg [0:`PV_COUNT-1];
	reg [31:0] value_reg [0:`PV_COUNT-1];
	reg [31:0] ch_cfg_reg [0:3];
	reg [31:0] ch_scale_reg [0:3];
	reg [8:0] ua_reg, la_reg, uw_reg, lw_reg;
	reg status_individual_reg;
	reg [8:0] sup_pending_reg, sup_keep_reg;
	reg [20:0] tick_cnt_reg;
	reg [28:0] help_cnt_reg;
	reg [2:0] key_sync_reg, edit_sync_reg, safe_sync_reg;
	reg key_filt_reg, edit_filt_reg, safe_filt_reg;
	reg wr_pend_reg;
	reg [11:0] wr_addr_reg;
	reg [31:0] rd_mux;
	reg [8:0] alarm_any, warn_any;
	wire [8:0] ua_next, la_next, uw_next, lw_next;
	wire addr_phase = hsel && htrans[1] && hready;
	wire [3:0] a_pv = haddr[8:5];
	wire [2:0] a_slot = haddr[4:2];
	wire [3:0] a_g = haddr[5:2];
	wire [3:0] w_pv = wr_addr_reg[8:5];
	wire [2:0] w_slot = wr_addr_reg[4:2];
	wire [3:0] w_g = wr_addr_reg[5:2];
	wire [5:0] w_lim_idx = w_pv * 6'd5 + {3'b000, w_slot};
	wire [5:0] a_lim_idx = a_pv * 6'd5 + {3'b000, a_slot};
	wire w_pv_blk = !wr_addr_reg[9] && (w_pv < `PV_COUNT);
	wire w_glb = wr_addr_reg[9] && (wr_addr_reg[8:6] == 3'b000);
	wire do_write = wr_pend_reg && hready;
	wire cfg_write_ok = do_write && edit_filt_reg;
	wire tick = (tick_cnt_reg == UPDATE_CYCLES - 1);
	integer i;

	genvar g;
	generate
		for (g = 0; g < `PV_COUNT; g = g + 1)
		begin : pv_eval
			wire [31:0] hy = lim_reg[g * 5 + `SLOT_HYST];
			assign ua_next[g] = eval_limit(ua_reg[g], 1'b1, shadow_reg[g], lim_reg[g * 5 + `SLOT_UPPER_ALARM], hy);
			assign la_next[g] = eval_limit(la_reg[g], 1'b0, shadow_reg[g], lim_reg[g * 5 + `SLOT_LOWER_ALARM], hy);
			// Hysteresis is an alarm setting, so warnings always clear at their own limit.
			assign uw_next[g] = eval_limit(uw_reg[g], 1'b1, shadow_reg[g], lim_reg[g * 5 + `SLOT_UPPER_WARN],
				32'h00000000);
			assign lw_next[g] = eval_limit(lw_reg[g], 1'b0, shadow_reg[g], lim_reg[g * 5 + `SLOT_LOWER_WARN],
				32'h00000000);
		end
	endgenerate

	// Asynchronous pins: a level counts once the second and third stage agree.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			key_sync_reg <= 3'b000;
			edit_sync_reg <= 3'b000;
			safe_sync_reg <= 3'b000;
			key_filt_reg <= 1'b0;
			edit_filt_reg <= 1'b0;
			safe_filt_reg <= 1'b0;
		end
		else
		begin
			key_sync_reg <= {key_sync_reg[1:0], key_press_pin};
			edit_sync_reg <= {edit_sync_reg[1:0], edit_access_pin};
			safe_sync_reg <= {safe_sync_reg[1:0], safety_rated_pin};
			if (key_sync_reg[1] == key_sync_reg[2])
				key_filt_reg <= key_sync_reg[2];
			if (edit_sync_reg[1] == edit_sync_reg[2])
				edit_filt_reg <= edit_sync_reg[2];
			if (safe_sync_reg[1] == safe_sync_reg[2])
				safe_filt_reg <= safe_sync_reg[2];
		end
	end

	// A key pulse shorter than the agreement window of the synchroniser is dropped as a bounce.
	wire key_event = (key_sync_reg[1] == key_sync_reg[2]) && key_sync_reg[2] && !key_filt_reg;

	// Update period divider and limit evaluation.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tick_cnt_reg <= 21'h000000;
			update_tick <= 1'b0;
			ua_reg <= 9'h000;
			la_reg <= 9'h000;
			uw_reg <= 9'h000;
			lw_reg <= 9'h000;
			for (i = 0; i < `PV_COUNT; i = i + 1)
			begin
				shadow_reg[i] <= 32'h00000000;
				value_reg[i] <= 32'h00000000;
			end
		end
		else
		begin
			tick_cnt_reg <= tick ? 21'h000000 : tick_cnt_reg + 21'h000001;
			// The tick output leads the alarm outputs by one cycle, as those are registered from the new state.
			update_tick <= tick;
			// The shadow copy lets the front-end load at any rate while one evaluation sees a consistent set.
			if (pv_load && pv_sel < `PV_COUNT)
				shadow_reg[pv_sel] <= pv_data;
			if (tick)
			begin
				ua_reg <= ua_next;
				la_reg <= la_next;
				uw_reg <= uw_next;
				lw_reg <= lw_next;
				for (i = 0; i < `PV_COUNT; i = i + 1)
					value_reg[i] <= shadow_reg[i];
			end
		end
	end

	// Outputs of the limit function.
	always @*
	begin
		alarm_any = ua_reg | la_reg;
		warn_any = uw_reg | lw_reg;
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			alarm_out <= 9'h000;
			warn_out <= 9'h000;
			failsafe_out <= 4'h0;
			help_show <= 1'b0;
			read_only_view <= 1'b1;
			help_cnt_reg <= 29'h00000000;
		end
		else
		begin
			if (status_individual_reg)
			begin
				alarm_out <= alarm_any & sup_keep_reg;
				warn_out <= warn_any;
			end
			else
			begin
				alarm_out <= 9'h000;
				warn_out <= 9'h000;
			end
			// Fail-safe looks at alarms before suppression, so hiding an alarm never hides its output reaction.
			for (i = 0; i < 4; i = i + 1)
				failsafe_out[i] <= output_active(ch_cfg_reg[i]) &&
					alarm_any[ch_cfg_reg[i][`CH_SEL_MSB:0]];
			read_only_view <= !edit_filt_reg;
			// The idle count restarts on every key, so help only appears after a quiet spell.
			if (key_event || !edit_filt_reg)
			begin
				help_cnt_reg <= 29'h00000000;
				help_show <= 1'b0;
			end
			else if (help_cnt_reg == HELP_CYCLES - 1)
				help_show <= 1'b1;
			else
				help_cnt_reg <= help_cnt_reg + 29'h00000001;
		end
	end

	// Read data is selected in the address phase so the slave answers with no wait state.
	always @*
	begin
		rd_mux = 32'h00000000;
		if (!haddr[9])
		begin
			if (a_pv < `PV_COUNT)
			begin
				case (a_slot)
					`SLOT_RESOLUTION: rd_mux = res_reg[a_pv];
					`SLOT_VALUE: rd_mux = value_reg[a_pv];
					`SLOT_STATUS: rd_mux = {28'h0000000, lw_reg[a_pv], uw_reg[a_pv], la_reg[a_pv], ua_reg[a_pv]};
					default: rd_mux = lim_reg[a_lim_idx];
				endcase
			end
		end
		else if (haddr[8:6] == 3'b000)
		begin
			case (a_g)
				`GREG_CTRL: rd_mux = {31'h00000000, status_individual_reg};
				`GREG_SUP_SELECT: rd_mux = {23'h000000, sup_pending_reg};
				`GREG_SUP_SAVE: rd_mux = {23'h000000, sup_keep_reg};
				`GREG_VIEW: rd_mux = {29'h00000000, safe_filt_reg, help_show, read_only_view};
				4'h4, 4'h5, 4'h6, 4'h7: rd_mux = ch_cfg_reg[a_g[1:0]];
				4'h8, 4'h9, 4'ha, 4'hb: rd_mux = ch_scale_reg[a_g[1:0]];
				`GREG_SUMMARY: rd_mux = {7'h00, warn_any, 7'h00, alarm_any};
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	// AHB-Lite slave: always ready, always OKAY.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			// A write is held over to its data phase, because hwdata only arrives one cycle after the address.
			if (hready)
			begin
				wr_pend_reg <= addr_phase && hwrite;
				wr_addr_reg <= haddr;
				if (addr_phase && !hwrite)
					hrdata <= rd_mux;
			end
		end
	end

	// Register writes.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (i = 0; i < NLIM; i = i + 1)
				lim_reg[i] <= 32'h00000000;
			for (i = 0; i < `PV_COUNT; i = i + 1)
				res_reg[i] <= `RESOLUTION_RESET;
			for (i = 0; i < 4; i = i + 1)
			begin
				ch_cfg_reg[i] <= 32'h00000000;
				ch_scale_reg[i] <= `SCALE_RESET;
			end
			status_individual_reg <= 1'b0;
			sup_pending_reg <= 9'h000;
			sup_keep_reg <= 9'h1ff;
		end
		else if (do_write)
		begin
			if (w_pv_blk && cfg_write_ok)
			begin
				if (w_slot < `LIMITS_PER_PV)
					lim_reg[w_lim_idx] <= hwdata;
				else if (w_slot == `SLOT_RESOLUTION)
					res_reg[w_pv] <= hwdata;
			end
			else if (w_glb)
			begin
				if (w_g == `GREG_CTRL && cfg_write_ok)
					status_individual_reg <= hwdata[0];
				else if (w_g == `GREG_SUP_SELECT)
					sup_pending_reg <= hwdata[8:0];
				// Only the save strobe makes a new mask visible; the pending mask alone changes nothing.
				else if (w_g == `GREG_SUP_SAVE && hwdata[0])
					sup_keep_reg <= sup_pending_reg;
				else if (w_g[3:2] == 2'b01 && cfg_write_ok &&
					ch_allowed(w_g[1:0], hwdata[`CH_SEL_MSB:0], safe_filt_reg))
				begin
					ch_cfg_reg[w_g[1:0]] <= {25'h0000000, hwdata[6:0]};
					if (hwdata[`CH_SEL_MSB:0] == `PV_DENSITY &&
						ch_cfg_reg[w_g[1:0]][`CH_SEL_MSB:0] != `PV_DENSITY)
						ch_scale_reg[w_g[1:0]] <= `SCALE_DENSITY_DEFAULT;
				end
				else if (w_g[3:2] == 2'b10 && cfg_write_ok)
					ch_scale_reg[w_g[1:0]] <= hwdata;
			end
		end
	end

endmodule // process_limit_monitor

/* File: tb/front_end_model.sv */
// Purpose: Measurement front-end that strobes process values.
// Assumes: Same clock as the monitor.
// Notes: Idle value lines toggle so stale data is never reused.
`timescale 1ns/1ns
module front_end_model (
	input wire hclk,
	input wire req,
	input wire [3:0] sel,
	input wire [31:0] data,
	output logic pv_load = 1'b0,
	output logic [3:0] pv_sel = 4'h0,
	output logic [31:0] pv_data = 32'h00000000
);
	always @(posedge hclk)
	begin
		pv_load <= req;
		pv_sel <= req ? sel : ~pv_sel;
		pv_data <= req ? data : ~pv_data;
	end
endmodule // front_end_model

/* File: tb/plm_check_monitor.sv */
// Purpose: Port assertions of the limit monitor.
// Assumes: One clock, reset async active low.
// Notes: Bound to every monitor instance.
`timescale 1ns/1ns
module plm_checker #(
	parameter int UPDATE_CYCLES = 20
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire edit_access_pin,
	input wire [8:0] warn_out,
	input wire [3:0] failsafe_out,
	input wire update_tick,
	input wire help_show,
	input wire read_only_view
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Seven samples cover the three-flop pin synchroniser with margin.
	sequence edit_on;
		edit_access_pin [*7];
	endsequence
	sequence edit_off;
		!edit_access_pin [*7];
	endsequence
	AST_TICK_PULSE: assert property (update_tick |=> !update_tick)
		else $error("tick longer than one cycle");
	AST_TICK_PERIOD: assert property (update_tick |-> ##[UPDATE_CYCLES:UPDATE_CYCLES] update_tick)
		else $error("tick period wrong");
	AST_WARN_HOLD: assert property ((!$past(update_tick) && !$past(hwrite) && !$past(hwrite, 2) && !$past(hwrite, 3)
		&& !$past(hwrite, 4)) |-> $stable(warn_out))
		else $error("warning changed between ticks");
	AST_FS_TIME: assert property (($changed(failsafe_out) && !$past(hwrite, 2) && !$past(hwrite, 3))
		|-> $past(update_tick))
		else $error("fail-safe changed off the evaluation");
	AST_RO_ON: assert property (edit_off |-> read_only_view)
		else $error("editable view without access");
	AST_RO_OFF: assert property (edit_on |-> !read_only_view)
		else $error("read-only view with access");
	AST_HELP_EDIT: assert property (edit_off |-> !help_show)
		else $error("help shown outside edit view");
	AST_RD_HOLD: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	AST_OKAY: assert property (hreadyout && !hresp)
		else $error("bus wait or error response");
endmodule // plm_checker
bind process_limit_monitor plm_checker #(.UPDATE_CYCLES(UPDATE_CYCLES)) chk_i (.*);

/* File: tb/process_limit_monitor_tb.sv */
// Purpose: Self-checking bench of the limit monitor.
// Assumes: Short update and help counts.
// Notes: Registers reached over AHB-Lite single words.
`timescale 1ns/1ns
`include "limit_monitor_consts.vh"
module process_limit_monitor_tb;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, key = 0, edit = 0, safe = 0, req = 0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h00000000, fdata = 32'h00000000, hrdata, rd, pv_data;
	logic [3:0] fsel = 4'h0, pv_sel, failsafe_out;
	logic [8:0] alarm_out, warn_out;
	logic hreadyout, hresp, pv_load, update_tick, help_show, read_only_view;
	int err_total = 0, tests_run = 0, cyc = 0;
	initial forever #4 hclk = ~hclk;
	front_end_model fe (.hclk(hclk), .req(req), .sel(fsel), .data(fdata), .pv_load(pv_load), .pv_sel(pv_sel),
		.pv_data(pv_data));
	process_limit_monitor #(.UPDATE_CYCLES(20), .HELP_CYCLES(30)) uut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pv_load(pv_load),
		.pv_sel(pv_sel), .pv_data(pv_data), .key_press_pin(key), .edit_access_pin(edit),
		.safety_rated_pin(safe), .alarm_out(alarm_out), .warn_out(warn_out), .failsafe_out(failsafe_out),
		.update_tick(update_tick), .help_show(help_show), .read_only_view(read_only_view));
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel <= 0;
		htrans <= 2'h0;
		hwrite <= 0;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] exp);
		xfer(0, a, 32'h00000000);
		chk(n, rd, exp);
	endtask
	// Two ticks make sure the evaluation saw the latest load.
	task automatic tk;
		repeat (2)
		begin
			@(posedge hclk);
			while (!update_tick) @(posedge hclk);
		end
		@(posedge hclk);
	endtask
	task automatic feed(input logic [3:0] s, input logic [31:0] d);
		req <= 1;
		fsel <= s;
		fdata <= d;
		@(posedge hclk);
		req <= 0;
		tk;
	endtask
	task automatic t_reset;
		rdc("resolution", 12'h014, `RESOLUTION_RESET);
		rdc("saved mask", 12'h208, 32'h000001ff);
		rdc("view", 12'h20c, 32'h00000001);
		rdc("unmapped", 12'h1e0, 32'h00000000);
		xfer(1, 12'h000, 32'h00000064);
		rdc("locked limit", 12'h000, 32'h00000000);
		$display("test reset done");
	endtask
	task automatic t_lim;
		edit <= 1;
		repeat (8) @(posedge hclk);
		xfer(1, 12'h000, 32'h00000064);
		xfer(1, 12'h010, 32'h0000000a);
		xfer(1, 12'h200, 32'h00000001);
		xfer(1, 12'h210, 32'h00000050);
		xfer(1, 12'h214, 32'h00000051);
		xfer(1, 12'h02c, 32'hffffff9c);
		rdc("limit", 12'h000, 32'h00000064);
		feed(0, 32'h00000065);
		rdc("status set", 12'h01c, 32'h00000005);
		chk("fail-safe on", failsafe_out, 32'h00000001);
		chk("upper warn", warn_out, 32'h00000001);
		feed(0, 32'h0000005f);
		rdc("status hyst", 12'h01c, 32'h00000005);
		feed(0, 32'h00000059);
		rdc("status clear", 12'h01c, 32'h00000004);
		chk("fail-safe off", failsafe_out, 32'h00000000);
		feed(0, 32'h00000064);
		chk("at limit", alarm_out, 32'h00000000);
		feed(1, 32'hffffffff);
		chk("reverse warn", warn_out, 32'h00000003);
		chk("warn no fs", failsafe_out, 32'h00000000);
		feed(1, 32'hffffff9b);
		chk("lower alarm", alarm_out, 32'h00000002);
		feed(1, 32'hffffff9c);
		chk("lower at limit", alarm_out, 32'h00000002);
		feed(1, 32'hffffff9d);
		chk("lower back", alarm_out, 32'h00000000);
		$display("test limits done");
	endtask
	task automatic t_out;
		feed(0, 32'h00000065);
		xfer(1, 12'h200, 32'h00000000);
		tk;
		chk("mode off", {alarm_out, warn_out}, 32'h00000000);
		xfer(1, 12'h200, 32'h00000001);
		xfer(1, 12'h204, 32'h000001fe);
		tk;
		chk("pending", alarm_out, 32'h00000001);
		xfer(1, 12'h208, 32'h00000001);
		tk;
		chk("saved", alarm_out, 32'h00000000);
		chk("fs unsuppressed", failsafe_out, 32'h00000001);
		$display("test outputs done");
	endtask
	task automatic t_route;
		xfer(1, 12'h218, 32'h00000003);
		rdc("density scale", 12'h228, `SCALE_DENSITY_DEFAULT);
		safe <= 1;
		repeat (8) @(posedge hclk);
		xfer(1, 12'h210, 32'h00000054);
		rdc("ch1 temp safe", 12'h210, 32'h00000050);
		xfer(1, 12'h210, 32'h00000053);
		rdc("ch1 density", 12'h210, 32'h00000053);
		safe <= 0;
		repeat (8) @(posedge hclk);
		xfer(1, 12'h210, 32'h00000054);
		rdc("ch1 temp", 12'h210, 32'h00000054);
		xfer(1, 12'h21c, 32'h00000058);
		rdc("ch4 any", 12'h21c, 32'h00000058);
		$display("test routing done");
	endtask
	task automatic t_help;
		key <= 1;
		repeat (4) @(posedge hclk);
		key <= 0;
		repeat (45) @(posedge hclk);
		chk("help idle", help_show, 32'h00000001);
		key <= 1;
		repeat (4) @(posedge hclk);
		key <= 0;
		repeat (8) @(posedge hclk);
		chk("help key", help_show, 32'h00000000);
		edit <= 0;
		repeat (8) @(posedge hclk);
		chk("read only", read_only_view, 32'h00000001);
		$display("test help done");
	endtask
	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			err_total++;
			report_and_stop;
		end
	end
	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		t_reset;
		t_lim;
		t_out;
		t_route;
		t_help;
		report_and_stop;
	end
endmodule // process_limit_monitor_tb
